// ### logic/itw_defs.svh
`ifndef ITW_DEFS_SVH
`define ITW_DEFS_SVH

// Register offsets, one 16-bit register per offset.
`define ITW_ADDR_STATUS 3'h0
`define ITW_ADDR_CONTROL 3'h1
`define ITW_ADDR_PERIODL 3'h2
`define ITW_ADDR_PERIODH 3'h3
`define ITW_ADDR_SNAPL 3'h4
`define ITW_ADDR_SNAPH 3'h5

// Field positions.
`define ITW_STATUS_TIMEOUT_BIT 0
`define ITW_STATUS_RUN_BIT 1
`define ITW_CTRL_IRQ_EN_BIT 0
`define ITW_CTRL_CONTINUOUS_SELECT_BIT 1
`define ITW_CTRL_START_BIT 2
`define ITW_CTRL_STOP_BIT 3

// Reset values.
`define ITW_CTRL_RESET 2'h0
`define ITW_TIMEOUT_RESET 1'h0

// Timing: clock period in nanoseconds and default timeout.
`define ITW_CLK_PERIOD_NS 100
`define ITW_DEFAULT_TIMEOUT_NS 1000000
`define ITW_DEFAULT_TIMEOUT_CLOCKS 10000

`endif

// ### logic/itw_pkg.sv
`default_nettype none
package itw_pkg;

  // Software-written control bits that persist.
  typedef struct packed {
    logic continuous_select;
    logic irq_on_timeout_enable;
  } itw_ctrl_t;

  // One register access request from the master.
  typedef struct packed {
    logic write;
    logic read;
    logic [2:0] addr;
    logic [15:0] wdata;
  } itw_req_t;

endpackage
`default_nettype wire

// ### logic/itw_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "itw_defs.svh"

// Functional notes
// - The timing element is a 32-bit down-counter.
// - Six 16-bit registers form the programming interface.
// - At zero the counter reloads at once from the 32-bit period.
// - Control register picks one-shot or continuous mode and irq enable.
// - Zero crossing with irq enabled asserts the interrupt request.
// - Writing either snapshot half copies the whole counter into both halves.
// - Optional timeout pulse is high exactly one cycle per zero crossing.
// - Watchdog option pulses reset request one cycle at each zero.
// - Reset request is non-maskable and meant to reset the whole system.
// - Watchdog leaves reset stopped; writing start bit starts it.
// - Once a watchdog is started, every stop attempt is ignored.
// - Watchdog period writes ignore data and reload the fixed period.
// - Without writeable period the fixed period is used, no period storage.
// - Without snapshot option the snapshot halves are absent.
// - Without start/stop control or watchdog the counter always runs.
// - Period halves reset to the build-time timeout period.
// - Time-unit timeout converts to the least cycle count not shorter.
// - Actual interval is one cycle longer than the stored period.
// - Timeout flag sets at each zero; cleared by writing zero to status.
// - Start and stop are write events; zero does nothing.
// - Period write loads the counter and stops it if start/stop exists, unless a watchdog has been started.
module itw_timer #(
  parameter bit WRITEABLE_PERIOD = 1'b1,
  parameter bit READABLE_SNAPSHOT = 1'b1,
  parameter bit START_STOP_CTRL = 1'b1,
  parameter bit TIMEOUT_PULSE_EN = 1'b1,
  parameter bit WATCHDOG_EN = 1'b0,
  parameter bit TIMEOUT_IN_NS = 1'b0,
  parameter longint unsigned TIMEOUT_NS = `ITW_DEFAULT_TIMEOUT_NS,
  parameter longint unsigned TIMEOUT_CLOCKS = `ITW_DEFAULT_TIMEOUT_CLOCKS
) (
  input wire logic clk,
  input wire logic reset,
  input wire itw_pkg::itw_req_t reg_req,
  output var logic [15:0] reg_rdata,
  output var logic reg_rvalid,
  output var logic irq,
  output var logic timeout_pulse,
  output var logic resetrequest
);

  // A time-unit timeout rounds up to whole cycles and never drops below one.
  localparam longint unsigned CLK_NS = `ITW_CLK_PERIOD_NS;
  localparam longint unsigned NS_CYCLES = (TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam longint unsigned RAW_CYCLES = TIMEOUT_IN_NS ? NS_CYCLES : TIMEOUT_CLOCKS;
  localparam longint unsigned CYCLES = (RAW_CYCLES < 1) ? 1 : RAW_CYCLES;
  // The counter spends one cycle at zero, so the stored value is one less.
  localparam logic [31:0] FIXED_PERIOD = 32'(CYCLES - 1);

  // Stop is only honoured when start/stop exists, and never once a watchdog runs.
  localparam bit START_ALLOWED = START_STOP_CTRL | WATCHDOG_EN;
  // Runs from reset only when nothing could ever start it.
  localparam bit RUN_AT_RESET = !START_STOP_CTRL && !WATCHDOG_EN;

  logic [31:0] count_r;
  logic [31:0] period_r;
  logic [31:0] snap_r;
  logic run_r;
  logic started_r;
  logic timeout_flag_r;
  itw_pkg::itw_ctrl_t ctrl_r;

  logic wr_status;
  logic wr_control;
  logic wr_period;
  logic wr_snap;
  logic start_ev;
  logic stop_ev;
  logic stop_allowed;
  logic continuous_select_eff;
  logic zero_hit;
  logic timeout_flag_nxt;
  logic [31:0] period_now;
  logic [31:0] period_written;
  itw_pkg::itw_ctrl_t ctrl_nxt;

  // Address decode of the write strobe into per-register events.
  always_comb
  begin
    wr_status = reg_req.write && (reg_req.addr == `ITW_ADDR_STATUS);
    wr_control = reg_req.write && (reg_req.addr == `ITW_ADDR_CONTROL);
    wr_period = reg_req.write && ((reg_req.addr == `ITW_ADDR_PERIODL) || (reg_req.addr == `ITW_ADDR_PERIODH));
    wr_snap = reg_req.write && ((reg_req.addr == `ITW_ADDR_SNAPL) || (reg_req.addr == `ITW_ADDR_SNAPH));
  end

  // Start and stop act only when written as one; a zero bit is no event.
  always_comb
  begin
    stop_allowed = START_STOP_CTRL && !(WATCHDOG_EN && started_r);
    start_ev = wr_control && reg_req.wdata[`ITW_CTRL_START_BIT] && START_ALLOWED;
    stop_ev = wr_control && reg_req.wdata[`ITW_CTRL_STOP_BIT] && stop_allowed;
    // Without start/stop the counter cannot halt, so it is always continuous.
    continuous_select_eff = ctrl_r.continuous_select || !START_STOP_CTRL || WATCHDOG_EN;
    zero_hit = run_r && (count_r == 32'h0000_0000);
  end

  // Period source: stored halves when writeable and not a watchdog, else the build-time constant.
  always_comb
  begin
    period_now = (WRITEABLE_PERIOD && !WATCHDOG_EN) ? period_r : FIXED_PERIOD;
    period_written = period_now;
    if (WRITEABLE_PERIOD && !WATCHDOG_EN)
    begin
      // The watchdog ignores written data and keeps the fixed period.
      if (reg_req.addr == `ITW_ADDR_PERIODL)
      begin
        period_written = {period_r[31:16], reg_req.wdata};
      end
      else
      begin
        period_written = {reg_req.wdata, period_r[15:0]};
      end
    end
  end

  // Stored period halves; they only change when the option provides them.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      period_r <= FIXED_PERIOD;
    end
    else if (wr_period && WRITEABLE_PERIOD && !WATCHDOG_EN)
    begin
      period_r <= period_written;
    end
  end

  // Down-counter: a period write loads it, zero reloads it, else it decrements while running.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_r <= FIXED_PERIOD;
    end
    else if (wr_period)
    begin
      count_r <= period_written;
    end
    else if (zero_hit)
    begin
      count_r <= period_now;
    end
    else if (run_r)
    begin
      count_r <= count_r - 32'h0000_0001;
    end
  end

  // Run state; a one-shot stops after its zero cycle but still reloads.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      run_r <= RUN_AT_RESET;
    end
    else if (stop_ev || (wr_period && stop_allowed))
    begin
      run_r <= 1'b0;
    end
    else if (start_ev)
    begin
      run_r <= 1'b1;
    end
    else if (zero_hit && !continuous_select_eff)
    begin
      run_r <= 1'b0;
    end
  end

  // Remembers that a watchdog has been started so stops stay locked out.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      started_r <= 1'b0;
    end
    else if (start_ev)
    begin
      started_r <= 1'b1;
    end
  end

  // Persistent control bits; start and stop are not stored.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_control)
    begin
      ctrl_nxt.irq_on_timeout_enable = reg_req.wdata[`ITW_CTRL_IRQ_EN_BIT];
      ctrl_nxt.continuous_select = reg_req.wdata[`ITW_CTRL_CONTINUOUS_SELECT_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_r <= `ITW_CTRL_RESET;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Timeout flag: a zero in the same cycle as the clear wins, so no event is lost.
  always_comb
  begin
    timeout_flag_nxt = timeout_flag_r;
    if (wr_status && !reg_req.wdata[`ITW_STATUS_TIMEOUT_BIT])
    begin
      timeout_flag_nxt = 1'b0;
    end
    if (zero_hit)
    begin
      timeout_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      timeout_flag_r <= `ITW_TIMEOUT_RESET;
    end
    else
    begin
      timeout_flag_r <= timeout_flag_nxt;
    end
  end

  // Snapshot copies the counter as it stands this cycle and then holds.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      snap_r <= 32'h0000_0000;
    end
    else if (wr_snap && READABLE_SNAPSHOT)
    begin
      snap_r <= count_r;
    end
  end

  // Interrupt follows the flag and enable; it uses next values to save a cycle.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= timeout_flag_nxt && ctrl_nxt.irq_on_timeout_enable;
    end
  end

  // One-cycle pulses at each zero; absent options hold them low.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      timeout_pulse <= 1'b0;
      resetrequest <= 1'b0;
    end
    else
    begin
      timeout_pulse <= zero_hit && TIMEOUT_PULSE_EN;
      // No mask applies here, since it must reset the whole system.
      resetrequest <= zero_hit && WATCHDOG_EN;
    end
  end

  // Registered read port; reserved bits and absent registers read as zero.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.read;
      reg_rdata <= 16'h0000;
      if (reg_req.read)
      begin
        case (reg_req.addr)
          `ITW_ADDR_STATUS: reg_rdata <= {14'h0000, run_r, timeout_flag_r};
          `ITW_ADDR_CONTROL: reg_rdata <= {14'h0000, ctrl_r.continuous_select, ctrl_r.irq_on_timeout_enable};
          `ITW_ADDR_PERIODL: reg_rdata <= period_now[15:0];
          `ITW_ADDR_PERIODH: reg_rdata <= period_now[31:16];
          `ITW_ADDR_SNAPL: reg_rdata <= READABLE_SNAPSHOT ? snap_r[15:0] : 16'h0000;
          `ITW_ADDR_SNAPH: reg_rdata <= READABLE_SNAPSHOT ? snap_r[31:16] : 16'h0000;
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### dv/itw_timer_checker.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the timer; the absent watchdog output comes in as a parameter.
module itw_timer_checker #(
  parameter bit WATCHDOG_EN = 1'b0,
  parameter bit TIMEOUT_PULSE_EN = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire itw_pkg::itw_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic irq,
  input wire logic timeout_pulse,
  input wire logic resetrequest
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_rvalid;
    reg_req.read |=> reg_rvalid ##1 (!reg_rvalid || $past(reg_req.read));
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  property p_no_rvalid;
    !reg_req.read |=> !reg_rvalid;
  endproperty
  a_no_rvalid: assert property (p_no_rvalid) else $error("answer without read");
  property p_rdata_idle;
    !reg_rvalid |-> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_reserved;
    reg_req.read && reg_req.addr > 3'h5 |=> reg_rdata == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("unmapped read not zero");
  property p_status_bits;
    reg_req.read && reg_req.addr == 3'h0 |=> reg_rdata[15:2] == 14'h0000;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status spare bits set");
  property p_pulse_one;
    timeout_pulse |=> !timeout_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
  property p_irq_hold;
    irq && !(reg_req.write && reg_req.addr < 3'h2) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  property p_irq_cause;
    $rose(irq) |-> timeout_pulse || $past(reg_req.write && reg_req.addr == 3'h1);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_no_wdog;
    !WATCHDOG_EN |-> !resetrequest;
  endproperty
  a_no_wdog: assert property (p_no_wdog) else $error("reset request present");
  property p_no_pulse;
    !TIMEOUT_PULSE_EN |-> !timeout_pulse;
  endproperty
  a_no_pulse: assert property (p_no_pulse) else $error("timeout pulse present");
  property p_wdog_one;
    resetrequest |=> !resetrequest;
  endproperty
  a_wdog_one: assert property (p_wdog_one) else $error("reset request too long");
endmodule
bind itw_timer itw_timer_checker #(.WATCHDOG_EN(WATCHDOG_EN), .TIMEOUT_PULSE_EN(TIMEOUT_PULSE_EN)) chk_u (.clk(clk),
  .reset(reset),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq(irq),
  .timeout_pulse(timeout_pulse), .resetrequest(resetrequest));
`default_nettype wire

// ### dv/itw_master.sv
`timescale 1ns/10ps
`default_nettype none
// Master model; requests change at the falling edge and span exactly one rising edge.
module itw_master (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  output var itw_pkg::itw_req_t reg_req
);
  initial reg_req = '0;
  // Idle address and data are inverted so nothing can lean on stale values.
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_req = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    reg_req = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // The answer stands one cycle, so it is taken at the next falling edge.
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_req = '{write: 1'b0, read: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk);
    reg_req.read = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk;
  logic reset;
  itw_pkg::itw_req_t reg_req;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic irq;
  logic timeout_pulse;
  logic resetrequest;
  itw_pkg::itw_req_t w_req;
  logic [15:0] w_rdata;
  logic w_rvalid;
  logic w_irq;
  logic w_pulse;
  logic w_resetrequest;
  logic [15:0] d;
  int err_count = 0;
  int n_compared = 0;
  int n;
  itw_timer #(.TIMEOUT_CLOCKS(8)) dut_u (.clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .irq(irq), .timeout_pulse(timeout_pulse), .resetrequest(resetrequest));
  itw_master master_u (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
  // Watchdog build: 650 ns rounds up to 7 clocks, which is stored as 6.
  itw_timer #(.WRITEABLE_PERIOD(1'b0), .READABLE_SNAPSHOT(1'b0), .START_STOP_CTRL(1'b0),
    .TIMEOUT_PULSE_EN(1'b0), .WATCHDOG_EN(1'b1), .TIMEOUT_IN_NS(1'b1), .TIMEOUT_NS(650))
    dut_w_u (.clk(clk), .reset(reset), .reg_req(w_req), .reg_rdata(w_rdata), .reg_rvalid(w_rvalid),
    .irq(w_irq), .timeout_pulse(w_pulse), .resetrequest(w_resetrequest));
  itw_master master_w_u (.clk(clk), .reg_rdata(w_rdata), .reg_req(w_req));
  // A 100 ns clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  task automatic print_verdict;
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Counts falling edges up to the next pulse; a lost pulse ends the run.
  task automatic wait_pulse(input bit wd);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((wd ? w_resetrequest : timeout_pulse) !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_count++;
      print_verdict();
    end
  endtask
  // Period 8 clocks is stored as 7; the new period 5 gives an interval of 6.
  initial
  begin
    reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    master_u.rd(3'h0, d); chk("status", d, 16'h0000);
    chk("rvalid", reg_rvalid, 1'b1);
    master_u.rd(3'h2, d); chk("periodl", d, 16'h0007);
    master_u.rd(3'h3, d); chk("periodh", d, 16'h0000);
    master_u.wr(3'h7, 16'hffff);
    master_u.rd(3'h6, d); chk("unmapped", d, 16'h0000);
    master_u.wr(3'h2, 16'h0005);
    master_u.wr(3'h3, 16'h0000);
    master_u.wr(3'h4, 16'h1234);
    master_u.rd(3'h4, d); chk("snapl", d, 16'h0005);
    master_u.rd(3'h5, d); chk("snaph", d, 16'h0000);
    master_u.wr(3'h1, 16'h0005);
    wait_pulse(1'b0); chk("interval", n, 6);
    chk("no reset request", resetrequest, 1'b0);
    chk("irq", irq, 1'b1);
    master_u.rd(3'h0, d); chk("one shot", d, 16'h0001);
    master_u.wr(3'h5, 16'h0000);
    master_u.rd(3'h4, d); chk("reload", d, 16'h0005);
    master_u.wr(3'h0, 16'h0000); chk("irq clear", irq, 1'b0);
    master_u.rd(3'h0, d); chk("flag clear", d, 16'h0000);
    master_u.wr(3'h1, 16'h0006);
    wait_pulse(1'b0); chk("irq masked", irq, 1'b0);
    wait_pulse(1'b0); chk("period", n, 6);
    master_u.wr(3'h1, 16'h0003); chk("irq enable", irq, 1'b1);
    master_u.rd(3'h0, d); chk("still running", d, 16'h0003);
    master_u.wr(3'h2, 16'h0040);
    master_u.rd(3'h0, d); chk("period stop", d[1], 1'b0);
    master_u.wr(3'h4, 16'h0000);
    master_u.wr(3'h1, 16'h0004);
    master_u.rd(3'h4, d); chk("snap hold", d, 16'h0040);
    master_u.wr(3'h1, 16'h0008);
    master_u.rd(3'h0, d); chk("stopped", d[1], 1'b0);
    master_u.wr(3'h3, 16'h0001);
    master_u.wr(3'h5, 16'h0000);
    master_u.rd(3'h5, d); chk("snaph wide", d, 16'h0001);
    master_u.rd(3'h4, d); chk("snapl wide", d, 16'h0040);
    // Watchdog: stopped at reset, stop ignored, a period write restarts the countdown just before zero.
    master_w_u.rd(3'h0, d); chk("wd stopped", d, 16'h0000);
    master_w_u.rd(3'h2, d); chk("wd period", d, 16'h0006);
    master_w_u.wr(3'h4, 16'hffff);
    master_w_u.rd(3'h4, d); chk("wd no snap", d, 16'h0000);
    master_w_u.wr(3'h1, 16'h0004);
    master_w_u.wr(3'h1, 16'h0008);
    master_w_u.rd(3'h0, d); chk("wd running", d, 16'h0002);
    master_w_u.wr(3'h2, 16'h1234);
    wait_pulse(1'b1); chk("wd interval", n, 7);
    chk("wd no pulse", w_pulse, 1'b0);
    master_w_u.rd(3'h2, d); chk("wd fixed", d, 16'h0006);
    print_verdict();
  end
endmodule
`default_nettype wire
